// ===== include/lpm_pkg.sv
// shared constants and types of the low power mode sequencer
package lpm_pkg;
  // oscillator stabilization wait, in cpu cycles
  localparam int         STAB_CYCLES  = 4096;
  localparam int         STAB_CNT_W   = 13;
  // interrupt mask level forced on entry to a power saving mode
  localparam logic [1:0] MASK_ENTRY   = 2'h2;
  // mask level after reset and while the reset vector is fetched
  localparam logic [1:0] MASK_RESET   = 2'h3;
  // watchdog_halt_option value that makes halt compatible with the watchdog
  localparam logic       WDG_HALT_OK  = 1'h1;
  // osc_interrupt_enable value that selects timebase-halt on halt
  localparam logic       OIE_AHALT    = 1'h1;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_WAIT  = 3'b001,
    ST_AHALT = 3'b010,
    ST_HALT  = 3'b011,
    ST_STAB  = 3'b100
  } lpm_state_type;
endpackage

// ===== src/lpm_sync2.sv
// two flip-flop synchroniser for a level from a pin
`timescale 1ns/100ps
module lpm_sync2 (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule // lpm_sync2

// ===== src/lpm_stab_counter.sv
// oscillator stabilization down counter
`timescale 1ns/100ps
module lpm_stab_counter
  import lpm_pkg::*;
#(
  parameter int CYCLES = STAB_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  logic [STAB_CNT_W-1:0] cnt_reg;
  logic [STAB_CNT_W-1:0] cnt_next;
  logic                  busy_reg;
  logic                  busy_next;

  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    if (start) begin
      cnt_next  = STAB_CNT_W'(CYCLES - 1);
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == '0) begin
        busy_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign busy = busy_reg;
  // last of the CYCLES busy cycles
  assign done = busy_reg && (cnt_reg == '0);
endmodule // lpm_stab_counter

// ===== src/lpm_sequencer.sv
// power saving mode sequencer: wait, timebase-halt and full halt
`timescale 1ns/100ps
// Notes on behaviour
// - wait instruction stops the cpu; every peripheral stays clocked.
// - in wait the interrupt mask level is forced to 10b; nothing else changes.
// - wait ends on interrupt or reset, then the matching routine is entered.
// - on service the mask is saved, set to routine priority, restored on return.
// - halt gives full halt when oscillator interrupt enable is 0 unless a watchdog reset is raised instead, timebase-halt if 1.
// - timebase-halt ends on timebase, specific interrupts or reset; interrupts need no delay.
// - leaving timebase-halt waits for stabilization only when woken by reset.
// - entering timebase-halt forces mask 10b; pending interrupt wakes at once.
// - in timebase-halt only oscillator and timebase run; other peripherals unclocked.
// - with oscillator interrupt enabled, halt with active watchdog gives no watchdog reset.
// - full halt turns the oscillator off; cpu and peripherals stop.
// - full halt ends on specific interrupt or reset after 4096 stabilization cycles.
// - entering full halt forces mask 10b; pending interrupt wakes at once.
// - option bit decides whether halt with enabled watchdog causes a watchdog reset.
module lpm_sequencer
  import lpm_pkg::*;
#(
  parameter int STAB_WAIT = STAB_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       wfi_exec,
  input  wire logic       halt_exec,
  input  wire logic       osc_interrupt_enable,
  input  wire logic       watchdog_halt_option,
  input  wire logic       watchdog_active,
  input  wire logic       irq_pending,
  input  wire logic       irq_halt_wake,
  input  wire logic       timebase_irq,
  input  wire logic [1:0] irq_priority,
  input  wire logic       iret_exec,
  input  wire logic       reset_wake_pin,
  output logic            cpu_clk_en,
  output logic            periph_clk_en,
  output logic            osc_enable,
  output logic            timebase_clk_en,
  output logic [1:0]      cc_mask_level,
  output logic            cc_push,
  output logic            irq_service,
  output logic            reset_fetch,
  output logic            watchdog_reset_req,
  output logic [2:0]      mode
);
  import lpm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  lpm_state_type state_reg;
  lpm_state_type state_next;
  logic [1:0]    mask_reg;
  logic [1:0]    mask_next;
  logic [1:0]    saved_mask_reg;
  logic [1:0]    saved_mask_next;
  logic          by_reset_reg;
  logic          by_reset_next;
  logic          push_reg;
  logic          push_next;
  logic          service_reg;
  logic          service_next;
  logic          rfetch_reg;
  logic          rfetch_next;
  logic          wdg_reg;
  logic          wdg_next;
  logic          stab_start;
  logic          stab_busy;
  logic          stab_done;
  logic          reset_wake;

  // the reset pin is asynchronous to clk
  lpm_sync2 u_rst_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (reset_wake_pin),
    .sync_out (reset_wake)
  );

  lpm_stab_counter #(
    .CYCLES (STAB_WAIT)
  ) u_stab (
    .clk   (clk),
    .rst_b (rst_b),
    .start (stab_start),
    .busy  (stab_busy),
    .done  (stab_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next      = state_reg;
    mask_next       = mask_reg;
    saved_mask_next = saved_mask_reg;
    by_reset_next   = by_reset_reg;
    push_next       = 1'b0;
    service_next    = 1'b0;
    rfetch_next     = 1'b0;
    wdg_next        = 1'b0;
    stab_start      = 1'b0;
    if (iret_exec) begin
      mask_next = saved_mask_reg;
    end
    case (state_reg)
      ST_RUN: begin
        if (wfi_exec) begin
          state_next = ST_WAIT;
          mask_next  = MASK_ENTRY;
        end else if (halt_exec) begin
          if (osc_interrupt_enable == OIE_AHALT) begin
            state_next = ST_AHALT;
            mask_next  = MASK_ENTRY;
          end else if (watchdog_active && watchdog_halt_option != WDG_HALT_OK) begin
            wdg_next = 1'b1;
          end else begin
            state_next = ST_HALT;
            mask_next  = MASK_ENTRY;
          end
        end
      end
      ST_WAIT: begin
        if (reset_wake) begin
          state_next  = ST_RUN;
          rfetch_next = 1'b1;
          mask_next   = MASK_RESET;
        end else if (irq_pending) begin
          state_next      = ST_RUN;
          push_next       = 1'b1;
          service_next    = 1'b1;
          saved_mask_next = mask_reg;
          mask_next       = irq_priority;
        end
      end
      ST_AHALT: begin
        if (reset_wake) begin
          state_next    = ST_STAB;
          by_reset_next = 1'b1;
          stab_start    = 1'b1;
        end else if (timebase_irq || irq_halt_wake) begin
          state_next      = ST_RUN;
          push_next       = 1'b1;
          service_next    = 1'b1;
          saved_mask_next = mask_reg;
          mask_next       = irq_priority;
        end
      end
      ST_HALT: begin
        if (reset_wake || irq_halt_wake) begin
          state_next    = ST_STAB;
          by_reset_next = reset_wake;
          stab_start    = 1'b1;
        end
      end
      ST_STAB: begin
        if (stab_done) begin
          state_next = ST_RUN;
          if (by_reset_reg) begin
            rfetch_next = 1'b1;
            mask_next   = MASK_RESET;
          end else begin
            push_next       = 1'b1;
            service_next    = 1'b1;
            saved_mask_next = mask_reg;
            mask_next       = irq_priority;
          end
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg      <= ST_RUN;
      mask_reg       <= MASK_RESET;
      saved_mask_reg <= MASK_RESET;
      by_reset_reg   <= 1'b0;
      push_reg       <= 1'b0;
      service_reg    <= 1'b0;
      rfetch_reg     <= 1'b0;
      wdg_reg        <= 1'b0;
    end else begin
      state_reg      <= state_next;
      mask_reg       <= mask_next;
      saved_mask_reg <= saved_mask_next;
      by_reset_reg   <= by_reset_next;
      push_reg       <= push_next;
      service_reg    <= service_next;
      rfetch_reg     <= rfetch_next;
      wdg_reg        <= wdg_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu clocked only in run
  assign cpu_clk_en         = (state_reg == ST_RUN);
  assign periph_clk_en      = (state_reg == ST_RUN) || (state_reg == ST_WAIT);
  assign osc_enable         = (state_reg != ST_HALT);
  assign timebase_clk_en    = (state_reg != ST_HALT) && (state_reg != ST_STAB);
  assign cc_mask_level      = mask_reg;
  assign cc_push            = push_reg;
  assign irq_service        = service_reg;
  assign reset_fetch        = rfetch_reg;
  assign watchdog_reset_req = wdg_reg;
  assign mode               = state_reg;

  ////////////////////////////////////////////////////////////////////////////
  // named steps shared by the properties below
  sequence s_run_wfi;
    state_reg == ST_RUN && wfi_exec;
  endsequence

  sequence s_run_halt;
    state_reg == ST_RUN && !wfi_exec && halt_exec;
  endsequence

  sequence s_serviced;
    service_reg && cc_push && cpu_clk_en;
  endsequence

  property p_wfi_enter;
    @(posedge clk) disable iff (!rst_b)
    s_run_wfi |=> state_reg == ST_WAIT && cc_mask_level == MASK_ENTRY
                  && periph_clk_en && !cpu_clk_en;
  endproperty
  a_wfi_enter: assert property (p_wfi_enter) else $error("wait entry wrong");

  property p_wait_wake;
    @(posedge clk) disable iff (!rst_b)
    state_reg == ST_WAIT && irq_pending && !reset_wake && !iret_exec
      |=> s_serviced and (cc_mask_level == $past(irq_priority));
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("wait wake wrong");

  property p_restore;
    @(posedge clk) disable iff (!rst_b)
    iret_exec && state_reg == ST_RUN && !wfi_exec && !halt_exec
      |=> cc_mask_level == $past(saved_mask_reg);
  endproperty
  a_restore: assert property (p_restore) else $error("mask not restored");

  property p_halt_select;
    @(posedge clk) disable iff (!rst_b)
    s_run_halt ##0 osc_interrupt_enable |=> state_reg == ST_AHALT && !watchdog_reset_req
                                            && cc_mask_level == MASK_ENTRY;
  endproperty
  a_halt_select: assert property (p_halt_select) else $error("halt select wrong");

  property p_ahalt_fast;
    @(posedge clk) disable iff (!rst_b)
    state_reg == ST_AHALT && timebase_irq && !reset_wake && !iret_exec |=> s_serviced;
  endproperty
  a_ahalt_fast: assert property (p_ahalt_fast) else $error("slow interrupt exit");

  property p_ahalt_reset;
    @(posedge clk) disable iff (!rst_b)
    state_reg == ST_AHALT && reset_wake |=> (state_reg == ST_STAB) [*8];
  endproperty
  a_ahalt_reset: assert property (p_ahalt_reset) else $error("reset exit no delay");

  property p_ahalt_clocks;
    @(posedge clk) disable iff (!rst_b)
    state_reg == ST_AHALT |-> osc_enable && timebase_clk_en && !periph_clk_en && !cpu_clk_en;
  endproperty
  a_ahalt_clocks: assert property (p_ahalt_clocks) else $error("timebase-halt clocks");

  property p_halt_off;
    @(posedge clk) disable iff (!rst_b)
    state_reg == ST_HALT |-> !osc_enable && !periph_clk_en && !cpu_clk_en;
  endproperty
  a_halt_off: assert property (p_halt_off) else $error("full halt clocks");

  property p_halt_wake;
    @(posedge clk) disable iff (!rst_b)
    state_reg == ST_HALT && irq_halt_wake |=> (stab_busy && !cpu_clk_en) [*8];
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("full halt exit no delay");

  property p_stab_end;
    @(posedge clk) disable iff (!rst_b)
    state_reg == ST_STAB && stab_done |=> cpu_clk_en && (reset_fetch || irq_service);
  endproperty
  a_stab_end: assert property (p_stab_end) else $error("no resume after delay");

  property p_watchdog;
    @(posedge clk) disable iff (!rst_b)
    s_run_halt ##0 (!osc_interrupt_enable && watchdog_active && !watchdog_halt_option)
      |=> watchdog_reset_req && state_reg == ST_RUN ##1 !watchdog_reset_req;
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog halt reset wrong");

  property p_halt_enter;
    @(posedge clk) disable iff (!rst_b)
    s_run_halt ##0 (!osc_interrupt_enable && (!watchdog_active || watchdog_halt_option))
      |=> state_reg == ST_HALT && cc_mask_level == MASK_ENTRY;
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("full halt entry wrong");
endmodule // lpm_sequencer

// ===== tb/lpm_cpu_model.sv
// cpu core and interrupt source model on the far side of the sequencer
`timescale 1ns/100ps
module lpm_cpu_model #(
  parameter int ROUTINE = 3
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] raise,
  input  wire logic       irq_service,
  output logic            irq_pending,
  output logic            irq_halt_wake,
  output logic            timebase_irq,
  output logic            iret_exec
);
  logic [3:1] flag_reg;
  int         left;
  ////////////////////////////////////////////////////////////////////////////////
  // three wake sources, flags cleared on vector fetch
  // plain flags latch until fetched, so a pending one wakes at once later
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg  <= 3'h0;
      left      <= 0;
      iret_exec <= 1'b0;
    end else begin
      iret_exec <= (left == 1);
      if (left > 0) left <= left - 1;
      if (irq_service) begin
        flag_reg <= 3'h0;
        left     <= ROUTINE;
      end else if (raise != 2'h0) begin
        flag_reg[raise] <= 1'b1;
      end
    end
  end
  assign irq_pending   = |flag_reg;
  assign irq_halt_wake = flag_reg[2] | flag_reg[3];
  assign timebase_irq  = flag_reg[3];
endmodule // lpm_cpu_model

// ===== tb/lpm_sequencer_tb_top.sv
// self-checking bench of the power saving mode sequencer
`timescale 1ns/100ps
module lpm_sequencer_tb_top;
  import lpm_pkg::*;
  localparam int STAB = 16;
  logic       clk = 1'b0;
  logic       rst_b, wfi_exec, halt_exec, osc_interrupt_enable, watchdog_halt_option;
  logic       watchdog_active, irq_pending, irq_halt_wake, timebase_irq, iret_exec;
  logic       reset_wake_pin, cpu_clk_en, periph_clk_en, osc_enable, timebase_clk_en;
  logic       cc_push, irq_service, reset_fetch, watchdog_reset_req, refused;
  logic [1:0] irq_priority, cc_mask_level, raise;
  logic [2:0] mode;
  logic [2:0] em = ST_RUN;
  logic [1:0] emask = MASK_RESET;
  logic [1:0] esaved = MASK_RESET;
  logic       esvc = 1'b0, efetch = 1'b0, ewdg = 1'b0, erst = 1'b0, s1 = 1'b0, s2 = 1'b0;
  logic       rw;
  logic [1:0] mpre;
  int         ecnt, bad_count, num_checks, ent, wk;
  logic [31:0] seed = 32'h000001e0;
  logic [31:0] r;
  always #25 clk = ~clk;
  lpm_sequencer #(.STAB_WAIT(STAB)) uut (.clk(clk), .rst_b(rst_b), .wfi_exec(wfi_exec),
    .halt_exec(halt_exec), .osc_interrupt_enable(osc_interrupt_enable),
    .watchdog_halt_option(watchdog_halt_option), .watchdog_active(watchdog_active),
    .irq_pending(irq_pending), .irq_halt_wake(irq_halt_wake), .timebase_irq(timebase_irq),
    .irq_priority(irq_priority), .iret_exec(iret_exec), .reset_wake_pin(reset_wake_pin),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
    .timebase_clk_en(timebase_clk_en), .cc_mask_level(cc_mask_level), .cc_push(cc_push),
    .irq_service(irq_service), .reset_fetch(reset_fetch),
    .watchdog_reset_req(watchdog_reset_req), .mode(mode));
  lpm_cpu_model #(.ROUTINE(3)) cpu (.clk(clk), .rst_b(rst_b), .raise(raise),
    .irq_service(irq_service), .irq_pending(irq_pending), .irq_halt_wake(irq_halt_wake),
    .timebase_irq(timebase_irq), .iret_exec(iret_exec));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // save mask as it stood before the edge, load priority
  task automatic take_irq();
    esvc   = 1'b1;
    esaved = mpre;
    emask  = irq_priority;
    em     = ST_RUN;
  endtask
  task automatic take_rst();
    efetch = 1'b1;
    emask  = MASK_RESET;
    em     = ST_RUN;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reference model, reads inputs as they stood before the edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      em = ST_RUN;
      emask = MASK_RESET;
      {esvc, efetch, ewdg, s1, s2} = 5'h0;
    end else begin
      {esvc, efetch, ewdg} = 3'h0;
      rw = s2;
      s2 = s1;
      s1 = reset_wake_pin;
      mpre = emask;
      if (iret_exec) emask = esaved;
      case (em)
        ST_RUN: if (wfi_exec) begin
          em = ST_WAIT;
          emask = MASK_ENTRY;
        end else if (halt_exec) begin
          if (osc_interrupt_enable == OIE_AHALT) em = ST_AHALT;
          else if (watchdog_active && watchdog_halt_option != WDG_HALT_OK) ewdg = 1'b1;
          else em = ST_HALT;
          if (!ewdg) emask = MASK_ENTRY;
        end
        ST_WAIT: if (rw) take_rst();
          else if (irq_pending) take_irq();
        ST_AHALT: if (rw) begin
          em = ST_STAB;
          erst = 1'b1;
          ecnt = 0;
        end else if (timebase_irq || irq_halt_wake) take_irq();
        ST_HALT: if (rw || irq_halt_wake) begin
          em = ST_STAB;
          erst = rw;
          ecnt = 0;
        end
        default: begin
          ecnt++;
          if (ecnt == STAB && erst) take_rst();
          else if (ecnt == STAB) take_irq();
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(negedge clk) begin
    chk(mode, em);
    chk({cpu_clk_en, periph_clk_en}, {em == ST_RUN, em == ST_RUN || em == ST_WAIT});
    chk({osc_enable, timebase_clk_en}, {em != ST_HALT, em != ST_HALT && em != ST_STAB});
    chk(cc_mask_level, emask);
    chk({cc_push, irq_service, reset_fetch}, {esvc, esvc, efetch});
    chk(watchdog_reset_req, ewdg);
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #(10000 * 50);
    bad_count++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // entry kind by wake kind: irq, pin, already pending
  initial begin
    {wfi_exec, halt_exec, osc_interrupt_enable, watchdog_halt_option} = 4'h0;
    {watchdog_active, reset_wake_pin, irq_priority, raise} = 6'h0;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 36; i++) begin
      ent = i % 3;
      wk = (i / 3) % 3;
      r = rnd();
      refused = (ent == 2) && r[2] && !r[3];
      @(posedge clk);
      irq_priority <= r[1:0];
      watchdog_active <= r[2];
      watchdog_halt_option <= r[3];
      osc_interrupt_enable <= (ent == 1);
      if (wk == 2) raise <= (ent == 0) ? 2'h1 : 2'h2;
      @(posedge clk);
      raise <= 2'h0;
      if (ent == 0) wfi_exec <= 1'b1;
      else halt_exec <= 1'b1;
      @(posedge clk);
      {wfi_exec, halt_exec} <= 2'h0;
      repeat (1 + r[7:5]) @(posedge clk);
      if (wk != 2 && !refused) begin
        // ignored outside run
        halt_exec <= 1'b1;
        @(posedge clk);
        halt_exec <= 1'b0;
        if (wk == 1) reset_wake_pin <= 1'b1;
        else raise <= (ent == 0) ? 2'h1 : {1'b1, r[4] & (ent == 1)};
        @(posedge clk);
        {reset_wake_pin, raise} <= 3'h0;
      end
      repeat (STAB + 12) @(posedge clk);
    end
    close_out();
  end
endmodule // lpm_sequencer_tb_top
